// >>> core/ir_pulse_gen.sv
// Infrared pulse encoder for one transmit bit stream.
// Assumes a one-cycle sixteen-times baud tick and a bit-start strobe on the same clock.
`default_nettype none
module ir_pulse_gen
   import uart_feature_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Timing
   input  wire logic       tick16,
   input  wire logic       bit_start,
   // Data and mode
   input  wire logic       tx_bit,
   input  wire logic       ir_fast,
   // Encoded output
   output logic            ir_out_ff
);
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic [3:0] width;

   assign width = ir_fast ? IR11_TICKS : IR10_TICKS;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (bit_start && !tx_bit) begin
         nxt_cnt = width;
      end else if (tick16 && cnt_ff != 4'h0) begin
         nxt_cnt = cnt_ff - 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_ff    <= 4'h0;
         ir_out_ff <= 1'b0;
      end else begin
         cnt_ff    <= nxt_cnt;
         ir_out_ff <= (nxt_cnt != 4'h0);
      end
   end

   property p_width;
      @(posedge core_clk) disable iff (rst) bit_start && !tx_bit |=> ir_out_ff;
   endproperty
   a_width: assert property (p_width) else $error("ir pulse missing");
   c_ir_pulse: cover property (@(posedge core_clk) disable iff (rst) $fell(ir_out_ff));
endmodule : ir_pulse_gen
`default_nettype wire

// >>> core/uart_feature_core.sv
// Multidrop, infrared, sleep and loopback feature logic of the UART core.
// Assumes the serial engine, FIFOs and interrupt logic sit beside it on core_clk.
`default_nettype none
module uart_feature_core
   import uart_feature_pkg::*;
(
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // Configuration
   input  wire feature_cfg_t cfg,
   input  wire logic         divisor_nonzero,
   input  wire logic         addr_mark_set,
   // Serial engine
   input  wire logic         tick16,
   input  wire logic         tx_bit_start,
   input  wire logic         tsr_bit,
   input  wire logic         tsr_busy,
   input  wire logic         tsr_load,
   input  wire logic         rsr_busy,
   input  wire logic         rx_char_valid,
   input  wire rx_char_t     rx_char,
   input  wire logic         rts_req,
   input  wire logic         dtr_req,
   // Core status
   input  wire logic         int_pending,
   input  wire logic         tx_fifo_empty,
   input  wire logic         rx_fifo_empty,
   input  wire logic         thr_write,
   input  wire logic         msr_read,
   // Pins
   input  wire logic         rx_pin,
   input  wire modem_in_t    modem_pins,
   input  wire logic         sleep_pin,
   output logic              tx_pin_ff,
   output logic              rts_n_ff,
   output logic              dtr_n_ff,
   output logic              osc_run_ff,
   // Towards the core
   output logic              rx_serial_ff,
   output logic              tx_ninth_ff,
   output logic              addr_mark_ff,
   output logic              rx_push_ff,
   output rx_char_t          rx_push_char_ff,
   output logic              rx_par_err_ff,
   output logic              line_int_ff,
   output logic              rx_enabled_ff,
   output logic [3:0]        modem_delta_ff,
   output logic              wake_int_ff,
   output logic              asleep_ff
);
   // Pin synchronisers
   logic      rx_s1_ff, rx_s2_ff, rx_s3_ff;
   logic      slp_s1_ff, slp_s2_ff;
   modem_in_t mdm_s1_ff, mdm_s2_ff, mdm_s3_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_s1_ff  <= 1'b1;
         rx_s2_ff  <= 1'b1;
         rx_s3_ff  <= 1'b1;
         slp_s1_ff <= 1'b0;
         slp_s2_ff <= 1'b0;
         mdm_s1_ff <= '1;
         mdm_s2_ff <= '1;
         mdm_s3_ff <= '1;
      end else begin
         rx_s1_ff  <= rx_pin;
         rx_s2_ff  <= rx_s1_ff;
         rx_s3_ff  <= rx_s2_ff;
         slp_s1_ff <= sleep_pin;
         slp_s2_ff <= slp_s1_ff;
         mdm_s1_ff <= modem_pins;
         mdm_s2_ff <= mdm_s1_ff;
         mdm_s3_ff <= mdm_s2_ff;
      end
   end

   // Mode decoding
   logic auto_addr, normal_md, ir_fast_sel, rx_idle_lvl;
   assign auto_addr   = cfg.multidrop && cfg.enh_en && cfg.spec_char_en;
   assign normal_md   = cfg.multidrop && cfg.enh_en && !cfg.spec_char_en;
   assign ir_fast_sel = cfg.ir_en && cfg.ir_fast && cfg.enh_en;
   assign rx_idle_lvl = !cfg.ir_en;

   // Infrared receive decode: a light pulse means a zero bit; the line idles low in this mode
   logic rx_line;
   assign rx_line = cfg.ir_en ? !rx_s2_ff : rx_s2_ff;

   // Loopback routing to the receive shift register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_serial_ff <= 1'b1;
      end else begin
         rx_serial_ff <= cfg.loopback ? tsr_bit : rx_line;
      end
   end

   // Infrared encoder; its tick runs at the sixteen-times rate
   logic ir_tx;
   ir_pulse_gen u_ir (
      .core_clk  (core_clk),
      .rst       (rst),
      .tick16    (tick16),
      .bit_start (tx_bit_start),
      .tx_bit    (tsr_bit),
      .ir_fast   (ir_fast_sel),
      .ir_out_ff (ir_tx)
   );

   // Transmit pin and modem outputs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_pin_ff <= 1'b1;
         rts_n_ff  <= 1'b1;
         dtr_n_ff  <= 1'b1;
      end else begin
         if (cfg.loopback) begin
            tx_pin_ff <= 1'b1;
         end else if (cfg.ir_en) begin
            tx_pin_ff <= ir_tx;
         end else begin
            tx_pin_ff <= tsr_bit;
         end
         rts_n_ff <= cfg.loopback ? 1'b1 : !rts_req;
         dtr_n_ff <= cfg.loopback ? 1'b1 : !dtr_req;
      end
   end

   // Transmit address marking; a new mark request wins over the self-clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_mark_ff <= 1'b0;
         tx_ninth_ff  <= 1'b0;
      end else begin
         if (addr_mark_set) begin
            addr_mark_ff <= 1'b1;
         end else if (tsr_load) begin
            addr_mark_ff <= 1'b0;
         end
         if (tsr_load) begin
            tx_ninth_ff <= addr_mark_ff;
         end
      end
   end

   // Multidrop receive filter
   logic match;
   assign match = rx_char.data == cfg.slave_addr;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_enabled_ff   <= 1'b0;
         rx_push_ff      <= 1'b0;
         rx_push_char_ff <= '0;
         rx_par_err_ff   <= 1'b0;
         line_int_ff     <= 1'b0;
      end else begin
         rx_push_ff  <= 1'b0;
         line_int_ff <= 1'b0;
         if (rx_char_valid) begin
            rx_push_char_ff <= rx_char;
            rx_par_err_ff   <= rx_char.ninth;
            if (auto_addr) begin
               if (rx_char.ninth && match) begin
                  rx_enabled_ff <= 1'b1;
                  rx_push_ff    <= 1'b1;
                  line_int_ff   <= 1'b1;
               end else if (rx_char.ninth) begin
                  rx_enabled_ff <= 1'b0;
               end else begin
                  rx_push_ff <= rx_enabled_ff;
               end
            end else if (normal_md) begin
               rx_push_ff  <= rx_char.ninth || rx_enabled_ff;
               line_int_ff <= rx_char.ninth;
            end else begin
               rx_push_ff <= 1'b1;
            end
         end
      end
   end

   // Modem delta flags; a fresh change wins over the status read clear
   logic [3:0] mdm_chg;
   assign mdm_chg = cfg.loopback ? DELTA_CLEAR : (mdm_s3_ff ^ mdm_s2_ff);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         modem_delta_ff <= DELTA_CLEAR;
      end else begin
         modem_delta_ff <= (msr_read ? DELTA_CLEAR : modem_delta_ff) | mdm_chg;
      end
   end

   // Sleep control
   pwr_state_t st_ff;
   logic       can_sleep, wake_evt, rx_start;

   assign rx_start  = cfg.ir_en ? (!rx_s3_ff && rx_s2_ff) : (rx_s3_ff && !rx_s2_ff);
   assign can_sleep = !int_pending && cfg.sleep_en && modem_delta_ff == DELTA_CLEAR
                      && rx_s2_ff == rx_idle_lvl && divisor_nonzero
                      && tx_fifo_empty && rx_fifo_empty && !tsr_busy && !rsr_busy;
   assign wake_evt  = rx_start || thr_write || (mdm_chg != DELTA_CLEAR);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_ff <= PWR_RUN;
      end else begin
         unique case (st_ff)
            PWR_RUN: begin
               if (slp_s2_ff) begin
                  st_ff <= PWR_DRAIN;
               end else if (can_sleep && !wake_evt) begin
                  st_ff <= PWR_SLEEP_REG;
               end
            end
            PWR_DRAIN: begin
               if (!slp_s2_ff) begin
                  st_ff <= PWR_RUN;
               end else if (!tsr_busy && !rsr_busy) begin
                  st_ff <= PWR_SLEEP_PIN;
               end
            end
            PWR_SLEEP_REG: begin
               if (slp_s2_ff) begin
                  st_ff <= PWR_SLEEP_PIN;
               end else if (wake_evt || !cfg.sleep_en || int_pending) begin
                  st_ff <= PWR_RUN;
               end
            end
            PWR_SLEEP_PIN: begin
               if (!slp_s2_ff) begin
                  st_ff <= PWR_RUN;
               end
            end
         endcase
      end
   end

   logic nxt_asleep;
   assign nxt_asleep = st_ff == PWR_SLEEP_REG || st_ff == PWR_SLEEP_PIN;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         asleep_ff   <= 1'b0;
         osc_run_ff  <= 1'b1;
         wake_int_ff <= 1'b0;
      end else begin
         asleep_ff   <= nxt_asleep;
         osc_run_ff  <= !nxt_asleep;
         wake_int_ff <= cfg.wake_int_en && st_ff == PWR_SLEEP_REG && !slp_s2_ff && wake_evt;
      end
   end

   // Assertions
   property p_loop_tx;
      @(posedge core_clk) disable iff (rst) cfg.loopback |=> tx_pin_ff && rts_n_ff && dtr_n_ff;
   endproperty
   a_loop_tx: assert property (p_loop_tx) else $error("loopback pins not at mark");

   property p_loop_rx;
      @(posedge core_clk) disable iff (rst) cfg.loopback |=> rx_serial_ff == $past(tsr_bit);
   endproperty
   a_loop_rx: assert property (p_loop_rx) else $error("loopback path broken");

   property p_drop;
      @(posedge core_clk) disable iff (rst)
         auto_addr && rx_char_valid && !rx_char.ninth && !rx_enabled_ff |=> !rx_push_ff;
   endproperty
   a_drop: assert property (p_drop) else $error("data kept while receiver off");

   property p_match;
      @(posedge core_clk) disable iff (rst)
         auto_addr && rx_char_valid && rx_char.ninth && match |=> rx_push_ff && line_int_ff && rx_enabled_ff;
   endproperty
   a_match: assert property (p_match) else $error("matching address not taken");

   property p_mismatch;
      @(posedge core_clk) disable iff (rst)
         auto_addr && rx_char_valid && rx_char.ninth && !match |=> !rx_push_ff && !rx_enabled_ff;
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("foreign address kept");

   property p_mark;
      @(posedge core_clk) disable iff (rst) addr_mark_ff && tsr_load && !addr_mark_set |=> tx_ninth_ff && !addr_mark_ff;
   endproperty
   a_mark: assert property (p_mark) else $error("address mark not used once");

   property p_no_int_sleep;
      @(posedge core_clk) disable iff (rst) st_ff == PWR_RUN && int_pending && !slp_s2_ff |=> st_ff != PWR_SLEEP_REG;
   endproperty
   a_no_int_sleep: assert property (p_no_int_sleep) else $error("slept with interrupt pending");

   property p_pin_hold;
      @(posedge core_clk) disable iff (rst) st_ff == PWR_SLEEP_PIN && slp_s2_ff |=> st_ff == PWR_SLEEP_PIN;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin sleep ended early");

   property p_osc;
      @(posedge core_clk) disable iff (rst) nxt_asleep |=> !osc_run_ff;
   endproperty
   a_osc: assert property (p_osc) else $error("oscillator runs in sleep");

   property p_wake_int;
      @(posedge core_clk) disable iff (rst) !cfg.wake_int_en |=> !wake_int_ff;
   endproperty
   a_wake_int: assert property (p_wake_int) else $error("wake interrupt while disabled");

   // Checked against the raw enable, divisor and FIFO inputs, not can_sleep, so a break in those terms cannot hide
   property p_sleep_gate;
      @(posedge core_clk) disable iff (rst)
         st_ff == PWR_RUN && !(cfg.sleep_en && divisor_nonzero && tx_fifo_empty && rx_fifo_empty)
         |=> st_ff != PWR_SLEEP_REG;
   endproperty
   a_sleep_gate: assert property (p_sleep_gate) else $error("register sleep without its conditions");

   property p_reg_wake;
      @(posedge core_clk) disable iff (rst)
         st_ff == PWR_SLEEP_REG && !slp_s2_ff && thr_write |=> st_ff == PWR_RUN;
   endproperty
   a_reg_wake: assert property (p_reg_wake) else $error("transmit write did not wake");

   property p_drain;
      @(posedge core_clk) disable iff (rst)
         st_ff == PWR_DRAIN && (tsr_busy || rsr_busy) |=> st_ff != PWR_SLEEP_PIN;
   endproperty
   a_drain: assert property (p_drain) else $error("pin sleep before shifters idle");

   property p_normal_addr;
      @(posedge core_clk) disable iff (rst)
         normal_md && rx_char_valid && rx_char.ninth |=> rx_push_ff && line_int_ff && rx_par_err_ff;
   endproperty
   a_normal_addr: assert property (p_normal_addr) else $error("address byte not flagged");

   property p_loop_delta;
      @(posedge core_clk) disable iff (rst) cfg.loopback && !msr_read |=> $stable(modem_delta_ff);
   endproperty
   a_loop_delta: assert property (p_loop_delta) else $error("modem input seen in loopback");

   property p_ir_rx;
      @(posedge core_clk) disable iff (rst)
         cfg.ir_en && !cfg.loopback |=> rx_serial_ff != $past(rx_s2_ff);
   endproperty
   a_ir_rx: assert property (p_ir_rx) else $error("infrared receive not inverted");

   property p_delta_clear;
      @(posedge core_clk) disable iff (rst)
         msr_read && mdm_chg == DELTA_CLEAR |=> modem_delta_ff == DELTA_CLEAR;
   endproperty
   a_delta_clear: assert property (p_delta_clear) else $error("status read left deltas");

   c_reg_sleep: cover property (@(posedge core_clk) disable iff (rst) st_ff == PWR_SLEEP_REG);
   c_pin_sleep: cover property (@(posedge core_clk) disable iff (rst) st_ff == PWR_SLEEP_PIN);
   c_match:     cover property (@(posedge core_clk) disable iff (rst) auto_addr && rx_push_ff);
   c_loop:      cover property (@(posedge core_clk) disable iff (rst) cfg.loopback && rx_serial_ff == 1'b0);
endmodule : uart_feature_core
`default_nettype wire

// >>> inc/uart_feature_pkg.sv
// Constants and carrier types shared by the UART feature logic.
// Assumes one 250 MHz core clock and a synchronous active-high reset.
`default_nettype none
package uart_feature_pkg;
   localparam int unsigned CLK_HZ          = 250_000_000;
   localparam int unsigned OVERSAMPLE      = 16;
   localparam logic [3:0]  IR10_TICKS      = 4'h3;
   localparam logic [3:0]  IR11_TICKS      = 4'h4;
   localparam logic [3:0]  TICK_LAST       = 4'hF;
   localparam logic [2:0]  PAR_FORCE_ZERO  = 3'h7;
   localparam logic [7:0]  RESET_BYTE      = 8'h00;
   localparam logic [3:0]  DELTA_CLEAR     = 4'h0;

   // Configuration bits gathered from the control registers
   typedef struct packed {
      logic       multidrop;      // modem_status_reg bit 6
      logic       ir_fast;        // modem_status_reg bit 7
      logic       enh_en;         // enhanced_function_reg bit 4
      logic       spec_char_en;   // enhanced_function_reg bit 5
      logic [7:0] slave_addr;     // second_pause_char_reg
      logic       ir_en;          // modem_control_reg bit 6
      logic       loopback;       // modem_control_reg bit 4
      logic       sleep_en;       // interrupt_enable_reg bit 4
      logic       wake_int_en;    // fifo_control_reg bit 3
      logic [2:0] parity_field;   // line_control_reg bits 5:3
   } feature_cfg_t;

   // Received character with its ninth bit
   typedef struct packed {
      logic       ninth;
      logic [7:0] data;
   } rx_char_t;

   // Modem inputs, active low on the pins
   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic cd_n;
      logic ri_n;
   } modem_in_t;

   typedef enum logic [1:0] {PWR_RUN, PWR_DRAIN, PWR_SLEEP_REG, PWR_SLEEP_PIN} pwr_state_t;
endpackage : uart_feature_pkg
`default_nettype wire

// >>> verification/remote_line_model.sv
// Remote side of the serial line: drives the RX line and the modem inputs.
// Assumes the bench calls its tasks just after a rising clock edge.
`default_nettype none
module remote_line_model
   import uart_feature_pkg::*;
(
   // Lines towards the core
   output var logic      rx_line,
   output var modem_in_t modem_line
);
   timeunit 1ns;
   timeprecision 100ps;

   // Marking idle so that leaving loopback reports no false break
   initial begin
      rx_line    = 1'b1;
      modem_line = 4'hF;
   end

   task automatic set_rx(input logic v);
      rx_line = v;
   endtask : set_rx

   task automatic set_modem(input modem_in_t v);
      modem_line = v;
   endtask : set_modem
endmodule : remote_line_model
`default_nettype wire

// >>> verification/uart_feature_core_tb_top.sv
// Self-checking bench for the UART feature logic.
// Assumes tick16 may be held high so one sample tick equals one core clock.
`default_nettype none
module uart_feature_core_tb_top;
   import uart_feature_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic         core_clk, rst, divisor_nonzero, addr_mark_set, tick16, tx_bit_start;
   logic         tsr_bit, tsr_busy, tsr_load, rsr_busy, rx_char_valid, rts_req, dtr_req;
   logic         int_pending, tx_fifo_empty, rx_fifo_empty, thr_write, msr_read, sleep_pin;
   feature_cfg_t cfg;
   rx_char_t     rx_char;
   logic         rx_pin;
   modem_in_t    modem_pins;
   logic         tx_pin_ff, rts_n_ff, dtr_n_ff, osc_run_ff, rx_serial_ff, tx_ninth_ff;
   logic         addr_mark_ff, rx_push_ff, rx_par_err_ff, line_int_ff, rx_enabled_ff;
   logic         wake_int_ff, asleep_ff;
   rx_char_t     rx_push_char_ff;
   logic [3:0]   modem_delta_ff;
   logic [7:0]   push_cnt, lint_cnt, wake_cnt;
   int           errors, check_count;

   remote_line_model remote_line_model_i (.rx_line(rx_pin), .modem_line(modem_pins));

   uart_feature_core uart_feature_core_i (
      .core_clk(core_clk), .rst(rst), .cfg(cfg), .divisor_nonzero(divisor_nonzero),
      .addr_mark_set(addr_mark_set), .tick16(tick16), .tx_bit_start(tx_bit_start),
      .tsr_bit(tsr_bit), .tsr_busy(tsr_busy), .tsr_load(tsr_load), .rsr_busy(rsr_busy),
      .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rts_req(rts_req), .dtr_req(dtr_req),
      .int_pending(int_pending), .tx_fifo_empty(tx_fifo_empty), .rx_fifo_empty(rx_fifo_empty),
      .thr_write(thr_write), .msr_read(msr_read), .rx_pin(rx_pin), .modem_pins(modem_pins),
      .sleep_pin(sleep_pin), .tx_pin_ff(tx_pin_ff), .rts_n_ff(rts_n_ff), .dtr_n_ff(dtr_n_ff),
      .osc_run_ff(osc_run_ff), .rx_serial_ff(rx_serial_ff), .tx_ninth_ff(tx_ninth_ff),
      .addr_mark_ff(addr_mark_ff), .rx_push_ff(rx_push_ff), .rx_push_char_ff(rx_push_char_ff),
      .rx_par_err_ff(rx_par_err_ff), .line_int_ff(line_int_ff), .rx_enabled_ff(rx_enabled_ff),
      .modem_delta_ff(modem_delta_ff), .wake_int_ff(wake_int_ff), .asleep_ff(asleep_ff));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // One-cycle pulses are counted here so no scenario can miss one
   always @(posedge core_clk) begin
      if (rx_push_ff === 1'b1) push_cnt <= push_cnt + 8'h01;
      if (line_int_ff === 1'b1) lint_cnt <= lint_cnt + 8'h01;
      if (wake_int_ff === 1'b1) wake_cnt <= wake_cnt + 8'h01;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results

   task automatic send_char(input logic ninth, input logic [7:0] data);
      rx_char_valid = 1'b1;
      rx_char       = '{ninth: ninth, data: data};
      cyc(1);
      rx_char_valid = 1'b0;
      cyc(3);
   endtask : send_char

   task automatic t_auto_addr;
      cfg.multidrop    = 1'b1;
      cfg.enh_en       = 1'b1;
      cfg.spec_char_en = 1'b1;
      cfg.slave_addr   = 8'h5A;
      push_cnt = 8'h00;
      lint_cnt = 8'h00;
      send_char(1'b0, 8'h11);
      send_char(1'b1, 8'h33);
      check({push_cnt, 7'h00, rx_enabled_ff}, 16'h0000);
      send_char(1'b1, 8'h5A);
      check({rx_push_char_ff, rx_par_err_ff, rx_enabled_ff}, {5'h00, 9'h15A, 2'b11});
      check({push_cnt, lint_cnt}, 16'h0101);
      send_char(1'b0, 8'h22);
      check({push_cnt, rx_push_char_ff[7:0]}, 16'h0222);
      send_char(1'b1, 8'h5A);
      check({push_cnt, 7'h00, rx_par_err_ff}, 16'h0301);
      send_char(1'b1, 8'h33);
      send_char(1'b0, 8'h44);
      check({push_cnt, 7'h00, rx_enabled_ff}, 16'h0300);
   endtask : t_auto_addr

   task automatic t_normal_multidrop;
      cfg.spec_char_en = 1'b0;
      push_cnt = 8'h00;
      lint_cnt = 8'h00;
      send_char(1'b0, 8'h10);
      send_char(1'b1, 8'h77);
      check({push_cnt, lint_cnt}, 16'h0101);
      check({rx_push_char_ff, rx_par_err_ff}, {6'h00, 9'h177, 1'b1});
   endtask : t_normal_multidrop

   task automatic t_addr_mark;
      addr_mark_set = 1'b1;
      cyc(1);
      addr_mark_set = 1'b0;
      cyc(1);
      check({15'h0000, addr_mark_ff}, 16'h0001);
      tsr_load = 1'b1;
      cyc(1);
      tsr_load = 1'b0;
      cyc(1);
      check({14'h0000, tx_ninth_ff, addr_mark_ff}, 16'h0002);
      tsr_load = 1'b1;
      cyc(1);
      tsr_load = 1'b0;
      cyc(1);
      check({15'h0000, tx_ninth_ff}, 16'h0000);
   endtask : t_addr_mark

   task automatic ir_pulse(input logic b, input logic [15:0] exp);
      logic [15:0] n;
      n            = 16'h0000;
      tsr_bit      = b;
      tx_bit_start = 1'b1;
      cyc(1);
      tx_bit_start = 1'b0;
      repeat (12) begin
         cyc(1);
         if (tx_pin_ff === 1'b1) n = n + 16'h0001;
      end
      tsr_bit = 1'b1;
      check(n, exp);
   endtask : ir_pulse

   task automatic t_infrared;
      cfg = '0;
      cfg.parity_field = PAR_FORCE_ZERO;
      cfg.ir_en        = 1'b1;
      tick16           = 1'b1;
      remote_line_model_i.set_rx(1'b0);
      cyc(6);
      check({15'h0000, rx_serial_ff}, 16'h0001);
      cfg.ir_fast = 1'b1;
      ir_pulse(1'b0, {12'h000, IR10_TICKS});
      cfg.enh_en  = 1'b1;
      cfg.ir_fast = 1'b0;
      ir_pulse(1'b0, {12'h000, IR10_TICKS});
      ir_pulse(1'b1, 16'h0000);
      cfg.ir_fast = 1'b1;
      ir_pulse(1'b0, {12'h000, IR11_TICKS});
      remote_line_model_i.set_rx(1'b1);
      cyc(6);
      check({15'h0000, rx_serial_ff}, 16'h0000);
      cfg.ir_en = 1'b0;
      tick16    = 1'b0;
   endtask : t_infrared

   task automatic t_loopback;
      cfg.loopback = 1'b1;
      rts_req      = 1'b1;
      dtr_req      = 1'b1;
      for (int i = 0; i < 4; i++) begin
         tsr_bit = (i == 1 || i == 2);
         cyc(1);
         check({15'h0000, rx_serial_ff}, {15'h0000, tsr_bit});
      end
      tsr_bit = 1'b0;
      remote_line_model_i.set_modem(4'h0);
      cyc(6);
      check({tx_pin_ff, rts_n_ff, dtr_n_ff, modem_delta_ff}, 16'h0070);
      cfg.loopback = 1'b0;
      msr_read     = 1'b1;
      cyc(3);
      msr_read = 1'b0;
      check({13'h0000, tx_pin_ff, rts_n_ff, dtr_n_ff}, 16'h0000);
      tsr_bit = 1'b1;
      remote_line_model_i.set_modem(4'hF);
      cyc(6);
      check({12'h000, modem_delta_ff}, 16'h000F);
      msr_read = 1'b1;
      cyc(1);
      msr_read = 1'b0;
      cyc(1);
      check({12'h000, modem_delta_ff}, {12'h000, DELTA_CLEAR});
      rts_req = 1'b0;
      cyc(1);
      check({14'h0000, rts_n_ff, dtr_n_ff}, 16'h0002);
   endtask : t_loopback

   task automatic t_reg_sleep;
      cfg.sleep_en    = 1'b1;
      cfg.wake_int_en = 1'b1;
      cyc(8);
      check({15'h0000, asleep_ff}, 16'h0000);
      divisor_nonzero = 1'b1;
      cyc(8);
      check({14'h0000, asleep_ff, osc_run_ff}, 16'h0002);
      wake_cnt      = 8'h00;
      thr_write     = 1'b1;
      tx_fifo_empty = 1'b0;
      cyc(1);
      thr_write = 1'b0;
      cyc(4);
      check({wake_cnt, 7'h00, asleep_ff}, 16'h0100);
      tx_fifo_empty = 1'b1;
      int_pending   = 1'b1;
      cyc(8);
      check({15'h0000, asleep_ff}, 16'h0000);
      int_pending = 1'b0;
      cyc(8);
      check({15'h0000, asleep_ff}, 16'h0001);
      cfg.wake_int_en = 1'b0;
      wake_cnt        = 8'h00;
      rx_fifo_empty   = 1'b0;
      remote_line_model_i.set_rx(1'b0);
      cyc(6);
      check({wake_cnt, 7'h00, asleep_ff}, 16'h0000);
      remote_line_model_i.set_rx(1'b1);
      rx_fifo_empty = 1'b1;
      cyc(8);
      remote_line_model_i.set_modem(4'h7);
      cyc(8);
      check({15'h0000, asleep_ff}, 16'h0000);
      msr_read = 1'b1;
      cyc(1);
      msr_read = 1'b0;
      cyc(8);
      check({15'h0000, asleep_ff}, 16'h0001);
      cfg.sleep_en = 1'b0;
      cyc(4);
      check({15'h0000, asleep_ff}, 16'h0000);
   endtask : t_reg_sleep

   task automatic t_pin_sleep;
      tsr_busy      = 1'b1;
      rsr_busy      = 1'b1;
      tx_fifo_empty = 1'b0;
      sleep_pin     = 1'b1;
      cyc(8);
      tsr_busy = 1'b0;
      cyc(6);
      check({15'h0000, asleep_ff}, 16'h0000);
      rsr_busy = 1'b0;
      cyc(8);
      check({14'h0000, asleep_ff, osc_run_ff}, 16'h0002);
      thr_write = 1'b1;
      cyc(1);
      thr_write = 1'b0;
      remote_line_model_i.set_modem(4'hF);
      cyc(8);
      check({15'h0000, asleep_ff}, 16'h0001);
      sleep_pin = 1'b0;
      cyc(8);
      check({14'h0000, asleep_ff, osc_run_ff}, 16'h0001);
   endtask : t_pin_sleep

   // Watchdog span is about twenty times the roughly 240 cycles the scenarios need
   initial begin
      repeat (5000) @(posedge core_clk);
      errors++;
      results();
   end

   initial begin
      errors = 0;
      check_count = 0;
      push_cnt = 8'h00;
      lint_cnt = 8'h00;
      wake_cnt = 8'h00;
      rst = 1'b1;
      cfg = '0;
      cfg.parity_field = PAR_FORCE_ZERO;
      rx_char = '0;
      divisor_nonzero = 1'b0;
      addr_mark_set   = 1'b0;
      tick16          = 1'b0;
      tx_bit_start    = 1'b0;
      tsr_busy        = 1'b0;
      tsr_load        = 1'b0;
      rsr_busy        = 1'b0;
      rx_char_valid   = 1'b0;
      rts_req         = 1'b0;
      dtr_req         = 1'b0;
      int_pending     = 1'b0;
      thr_write       = 1'b0;
      msr_read        = 1'b0;
      sleep_pin       = 1'b0;
      tsr_bit = 1'b1;
      tx_fifo_empty = 1'b1;
      rx_fifo_empty = 1'b1;
      repeat (5) @(posedge core_clk);
      #1;
      rst = 1'b0;
      cyc(1);
      check({10'h000, tx_pin_ff, rts_n_ff, dtr_n_ff, osc_run_ff, rx_serial_ff, asleep_ff}, 16'h003E);
      t_auto_addr();
      t_normal_multidrop();
      t_addr_mark();
      t_infrared();
      t_loopback();
      t_reg_sleep();
      t_pin_sleep();
      results();
   end
endmodule : uart_feature_core_tb_top
`default_nettype wire
